// *** rtl/sig_pack_pkg.sv ***
// Shared constants, register map and types of the output signal packer.
package sig_pack_pkg;

  // Register map: five slot windows of 0x20 bytes, then global registers.
  localparam logic [7:0] SLOT_STRIDE = 8'h20;
  localparam logic [4:0] OFS_CFG = 5'h00;
  localparam logic [4:0] OFS_RES = 5'h04;
  localparam logic [4:0] OFS_OFFSET = 5'h08;
  localparam logic [4:0] OFS_MAX = 5'h0C;
  localparam logic [4:0] OFS_MIN = 5'h10;
  localparam logic [7:0] ADDR_CTRL = 8'hA0;
  localparam logic [7:0] ADDR_STATUS = 8'hA4;
  localparam logic [7:0] ADDR_PAY_LO = 8'hA8;
  localparam logic [7:0] ADDR_PAY_HI = 8'hAC;

  // Slot configuration word fields.
  localparam int CFG_TYPE_LSB = 0;
  localparam int CFG_INV_BIT = 3;
  localparam int CFG_BYTE_LSB = 4;
  localparam int CFG_BIT_LSB = 8;
  localparam int CFG_SRC_LSB = 16;

  // Values after reset.
  localparam logic [31:0] RST_CFG = 32'h0000_0110;
  localparam logic [31:0] RST_RES = 32'h0000_0001;
  localparam logic [31:0] RST_OFFSET = 32'h0000_0000;
  localparam logic [31:0] RST_MAX = 32'h0000_0001;
  localparam logic [31:0] RST_MIN = 32'h0000_0000;
  localparam logic [63:0] RST_PAYLOAD = 64'h0000_0000_0000_0000;

  // Logical value is a fraction, 0x1_0000 standing for 1.0.
  localparam int FRAC_BITS = 16;
  localparam logic [16:0] FRAC_ONE = 17'h1_0000;
  localparam logic [16:0] FRAC_HALF = 17'h0_8000;
  localparam int DIV_STEPS = 32;

  // Code table constants.
  localparam logic [31:0] C4_SPEC_LIM = 32'h0000_000C;
  localparam logic [31:0] C4_SPEC_ADD = 32'h0000_0002;
  localparam logic [31:0] C4_SPEC_SAT = 32'h0000_000D;
  localparam logic [31:0] C4_ERR = 32'h0000_000E;
  localparam logic [31:0] C4_NA = 32'h0000_000F;
  localparam logic [31:0] C8_VMAX = 32'h0000_00FA;
  localparam logic [31:0] C8_SPEC_LIM = 32'h0000_0003;
  localparam logic [31:0] C8_SPEC_ADD = 32'h0000_00FB;
  localparam logic [31:0] C8_SPEC_SAT = 32'h0000_00FD;
  localparam logic [31:0] C8_ERR = 32'h0000_00FE;
  localparam logic [31:0] C8_NA = 32'h0000_00FF;
  localparam logic [31:0] C16_VMAX = 32'h0000_FAFF;
  localparam logic [31:0] C16_SPEC_LIM = 32'h0000_0300;
  localparam logic [31:0] C16_SPEC_ADD = 32'h0000_FB00;
  localparam logic [31:0] C16_SPEC_SAT = 32'h0000_FDFF;
  localparam logic [31:0] C16_ERR_LIM = 32'h0000_0100;
  localparam logic [31:0] C16_ERR_ADD = 32'h0000_FE00;
  localparam logic [31:0] C16_ERR_SAT = 32'h0000_FEFF;
  localparam logic [31:0] C16_NA = 32'h0000_FFFF;
  localparam logic [31:0] C32_VMAX = 32'hFAFF_FFFF;
  localparam logic [31:0] C32_SPEC_LIM = 32'h0300_0000;
  localparam logic [31:0] C32_SPEC_ADD = 32'hFB00_0000;
  localparam logic [31:0] C32_SPEC_SAT = 32'hFDFF_FFFF;
  localparam logic [31:0] C32_ERR_LIM = 32'h0100_0000;
  localparam logic [31:0] C32_ERR_ADD = 32'hFE00_0000;
  localparam logic [31:0] C32_ERR_SAT = 32'hFEFF_FFFF;
  localparam logic [31:0] C32_NA = 32'hFFFF_FFFF;

  typedef enum logic [2:0] {
    SIG_UNDEF = 3'h0,
    SIG_BIT1 = 3'h1,
    SIG_BIT2 = 3'h2,
    SIG_BIT4 = 3'h3,
    SIG_BYTE1 = 3'h4,
    SIG_BYTE2 = 3'h5,
    SIG_BYTE4 = 3'h6
  } sig_type_t;

  typedef enum logic [1:0] {
    ST_VALID = 2'h0,
    ST_SPECIAL = 2'h1,
    ST_ERROR = 2'h2,
    ST_NA = 2'h3
  } sig_state_t;

  typedef enum logic [4:0] {
    PK_IDLE = 5'b00001,
    PK_LOAD = 5'b00010,
    PK_DIV = 5'b00100,
    PK_WRITE = 5'b01000,
    PK_DONE = 5'b10000
  } pack_state_t;

  typedef struct packed {
    logic [16:0] value;
    sig_state_t state;
    logic [31:0] logical_state_code;
  } logical_sig_t;

endpackage : sig_pack_pkg

// *** rtl/sig_packer.sv ***
// Packs up to five logical signals into the eight-byte payload of one CAN message.
// Contract
// - Slot type is undefined, 1/2/4-bit discrete or 1/2/4-byte continuous; default undefined.
// - Slot source selects any logical output or none; none is default.
// - Optional inversion of the logical signal before encoding, default off.
// - Byte position 1..8; continuous codes start with their low byte there.
// - Discrete code low bit sits at bit position 1..8 of its byte.
// - Continuous codes subtract an offset, default 0; discrete ignore it.
// - Continuous values scale between min and max limits, defaults 0 and 1.
// - Each signal carries state and state code, converted into its CAN code.
// - Valid discrete: 0 below one half, else 1; 1-bit non-valid gives 1.
// - 2-bit discrete: error gives 2, not available and special give 3.
// - 4-bit special gives code plus 2 below 12 else 13; error 14, missing 15.
// - 1-byte valid code lies in 0 to 0xFA.
// - 1-byte special code plus 251 below 3 else 253; error 254, missing 255.
// - 2-byte valid code lies in 0 to 0xFAFF; not available gives 65535.
// - 2-byte special gives code plus 64256 below 768, else 65023.
// - 2-byte error gives code plus 65024 below 256, else 65279.
// - 4-byte: valid up to 0xFAFFFFFF; special, error saturate; missing all ones.
//
// Our own choices: the address map and the APB slave port.
module sig_packer #(
  parameter int NUM_SLOTS = 5,
  parameter int NUM_SRC = 16
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Logical signals from the functional blocks
  input wire sig_pack_pkg::logical_sig_t [NUM_SRC-1:0] sources_in,
  input wire logic trigger_in,
  // Packed message payload, byte 1 in bits 7:0
  output logic [63:0] payload_out,
  output logic payload_valid_out,
  output logic busy_out
);

  logic [31:0] cfg [NUM_SLOTS];
  logic [31:0] res [NUM_SLOTS];
  logic [31:0] ofs [NUM_SLOTS];
  logic [31:0] lim_max [NUM_SLOTS];
  logic [31:0] lim_min [NUM_SLOTS];
  sig_pack_pkg::pack_state_t pstate;
  logic [2:0] slot;
  logic [5:0] step;
  logic [32:0] rem;
  logic [31:0] quo;
  logic [31:0] divisor;
  logic start_req;
  logic done_flag;
  logic [63:0] payload;

  logic apb_wr;
  logic apb_rd;
  logic [2:0] a_slot;
  logic [4:0] a_ofs;
  logic a_in_slots;
  logic a_mapped;

  assign apb_wr = psel_in && penable_in && pwrite_in;
  // Read data is loaded in the setup cycle so that it stands through the access phase.
  assign apb_rd = psel_in && !penable_in && !pwrite_in;
  assign a_slot = 3'(paddr_in / sig_pack_pkg::SLOT_STRIDE);
  assign a_ofs = paddr_in[4:0];
  assign a_in_slots = (int'(a_slot) < NUM_SLOTS) && (a_ofs <= sig_pack_pkg::OFS_MIN)
    && (a_ofs[1:0] == 2'b00);
  assign a_mapped = a_in_slots || (paddr_in == sig_pack_pkg::ADDR_CTRL)
    || (paddr_in == sig_pack_pkg::ADDR_STATUS) || (paddr_in == sig_pack_pkg::ADDR_PAY_LO)
    || (paddr_in == sig_pack_pkg::ADDR_PAY_HI);
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !a_mapped;

  always_ff @(posedge mclk_in)
  begin
    for (int i = 0; i < NUM_SLOTS; i++)
    begin
      if (rst_in)
      begin
        cfg[i] <= sig_pack_pkg::RST_CFG;
        res[i] <= sig_pack_pkg::RST_RES;
        ofs[i] <= sig_pack_pkg::RST_OFFSET;
        lim_max[i] <= sig_pack_pkg::RST_MAX;
        lim_min[i] <= sig_pack_pkg::RST_MIN;
      end
      else if (apb_wr && a_in_slots && int'(a_slot) == i)
      begin
        unique case (a_ofs)
          sig_pack_pkg::OFS_CFG: cfg[i] <= pwdata_in;
          sig_pack_pkg::OFS_RES: res[i] <= pwdata_in;
          sig_pack_pkg::OFS_OFFSET: ofs[i] <= pwdata_in;
          sig_pack_pkg::OFS_MAX: lim_max[i] <= pwdata_in;
          default: lim_min[i] <= pwdata_in;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      prdata_out <= 32'h0000_0000;
    end
    else if (apb_rd)
    begin
      if (a_in_slots)
      begin
        unique case (a_ofs)
          sig_pack_pkg::OFS_CFG: prdata_out <= cfg[a_slot];
          sig_pack_pkg::OFS_RES: prdata_out <= res[a_slot];
          sig_pack_pkg::OFS_OFFSET: prdata_out <= ofs[a_slot];
          sig_pack_pkg::OFS_MAX: prdata_out <= lim_max[a_slot];
          default: prdata_out <= lim_min[a_slot];
        endcase
      end
      else if (paddr_in == sig_pack_pkg::ADDR_STATUS)
      begin
        prdata_out <= {30'h0000_0000, done_flag, busy_out};
      end
      else if (paddr_in == sig_pack_pkg::ADDR_PAY_LO)
      begin
        prdata_out <= payload[31:0];
      end
      else if (paddr_in == sig_pack_pkg::ADDR_PAY_HI)
      begin
        prdata_out <= payload[63:32];
      end
      else
      begin
        prdata_out <= 32'h0000_0000;
      end
    end
  end

  // A start that arrives while busy is held so no request is lost.
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      start_req <= 1'b0;
    end
    else if (trigger_in || (apb_wr && paddr_in == sig_pack_pkg::ADDR_CTRL && pwdata_in[0]))
    begin
      start_req <= 1'b1;
    end
    else if (pstate == sig_pack_pkg::PK_IDLE)
    begin
      start_req <= 1'b0;
    end
  end

  // Current slot decode.
  sig_pack_pkg::sig_type_t s_type;
  logic [7:0] s_src;
  logic s_inv;
  logic [2:0] s_byte;
  logic [2:0] s_bit;
  logic s_live;
  sig_pack_pkg::logical_sig_t s_sig;
  logic [16:0] s_val;
  logic s_cont;

  assign s_type = sig_pack_pkg::sig_type_t'(cfg[slot][sig_pack_pkg::CFG_TYPE_LSB +: 3]);
  assign s_src = cfg[slot][sig_pack_pkg::CFG_SRC_LSB +: 8];
  assign s_inv = cfg[slot][sig_pack_pkg::CFG_INV_BIT];
  assign s_byte = 3'(cfg[slot][sig_pack_pkg::CFG_BYTE_LSB +: 4] - 4'h1);
  assign s_bit = 3'(cfg[slot][sig_pack_pkg::CFG_BIT_LSB +: 4] - 4'h1);
  assign s_live = (s_src != 8'h00) && (int'(s_src) <= NUM_SRC)
    && (s_type != sig_pack_pkg::SIG_UNDEF);
  assign s_sig = (s_src != 8'h00 && int'(s_src) <= NUM_SRC) ? sources_in[s_src - 8'h01]
    : '0;
  // Inversion mirrors the fraction about one half.
  assign s_val = s_inv ? 17'(sig_pack_pkg::FRAC_ONE - s_sig.value) : s_sig.value;
  assign s_cont = (s_type == sig_pack_pkg::SIG_BYTE1) || (s_type == sig_pack_pkg::SIG_BYTE2)
    || (s_type == sig_pack_pkg::SIG_BYTE4);

  // Physical value between the limits, less the offset.
  logic signed [63:0] span;
  logic signed [63:0] phys;
  logic signed [63:0] numer;
  logic [31:0] numer_sat;
  assign span = 64'($signed(lim_max[slot])) - 64'($signed(lim_min[slot]));
  assign phys = 64'($signed(lim_min[slot]))
    + ((64'($signed({47'h0, s_val})) * span) >>> sig_pack_pkg::FRAC_BITS);
  // Offset applies to continuous codes only.
  assign numer = $signed(res[slot]) < 0 ? 64'($signed(ofs[slot])) - phys
    : phys - 64'($signed(ofs[slot]));
  assign numer_sat = (numer < 0) ? 32'h0000_0000
    : (numer > 64'sh0000_0000_FFFF_FFFF) ? 32'hFFFF_FFFF : numer[31:0];

  logic [32:0] rem_sh;
  assign rem_sh = {rem[31:0], quo[31]};

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      pstate <= sig_pack_pkg::PK_IDLE;
      slot <= 3'h0;
      step <= 6'h00;
      rem <= 33'h0_0000_0000;
      quo <= 32'h0000_0000;
      divisor <= 32'h0000_0001;
    end
    else
    begin
      unique case (pstate)
        sig_pack_pkg::PK_IDLE:
        begin
          slot <= 3'h0;
          if (start_req)
          begin
            pstate <= sig_pack_pkg::PK_LOAD;
          end
        end
        sig_pack_pkg::PK_LOAD:
        begin
          rem <= 33'h0_0000_0000;
          quo <= numer_sat;
          divisor <= $signed(res[slot]) < 0 ? 32'(-res[slot]) : res[slot];
          step <= 6'h00;
          pstate <= s_cont && s_live && s_sig.state == sig_pack_pkg::ST_VALID
            ? sig_pack_pkg::PK_DIV : sig_pack_pkg::PK_WRITE;
        end
        sig_pack_pkg::PK_DIV:
        begin
          if (rem_sh >= {1'b0, divisor})
          begin
            rem <= rem_sh - {1'b0, divisor};
            quo <= {quo[30:0], 1'b1};
          end
          else
          begin
            rem <= rem_sh;
            quo <= {quo[30:0], 1'b0};
          end
          step <= step + 6'h01;
          if (int'(step) == sig_pack_pkg::DIV_STEPS - 1)
          begin
            pstate <= sig_pack_pkg::PK_WRITE;
          end
        end
        sig_pack_pkg::PK_WRITE:
        begin
          // The slot index stops at the last slot so no decode reads past the table.
          if (int'(slot) == NUM_SLOTS - 1)
          begin
            pstate <= sig_pack_pkg::PK_DONE;
          end
          else
          begin
            slot <= slot + 3'h1;
            pstate <= sig_pack_pkg::PK_LOAD;
          end
        end
        sig_pack_pkg::PK_DONE:
        begin
          pstate <= sig_pack_pkg::PK_IDLE;
        end
      endcase
    end
  end

  // State and state code mapped to the CAN code.
  logic [31:0] enc;
  logic [31:0] sc;
  logic hi;
  always_comb
  begin
    sc = s_sig.logical_state_code;
    hi = (s_val >= sig_pack_pkg::FRAC_HALF);
    enc = 32'h0000_0000;
    unique case (s_type)
      sig_pack_pkg::SIG_BIT1:
        // One-bit: any non-valid state reads as one.
        enc = (s_sig.state == sig_pack_pkg::ST_VALID) ? {31'h0, hi} : 32'h0000_0001;
      sig_pack_pkg::SIG_BIT2:
        enc = (s_sig.state == sig_pack_pkg::ST_VALID) ? {31'h0, hi}
          : (s_sig.state == sig_pack_pkg::ST_ERROR) ? 32'h0000_0002 : 32'h0000_0003;
      sig_pack_pkg::SIG_BIT4:
        // Four-bit special range and fixed codes.
        unique case (s_sig.state)
          sig_pack_pkg::ST_VALID: enc = {31'h0, hi};
          sig_pack_pkg::ST_SPECIAL: enc = (sc < sig_pack_pkg::C4_SPEC_LIM)
            ? sc + sig_pack_pkg::C4_SPEC_ADD : sig_pack_pkg::C4_SPEC_SAT;
          sig_pack_pkg::ST_ERROR: enc = sig_pack_pkg::C4_ERR;
          sig_pack_pkg::ST_NA: enc = sig_pack_pkg::C4_NA;
        endcase
      sig_pack_pkg::SIG_BYTE1:
        unique case (s_sig.state)
          sig_pack_pkg::ST_VALID: enc = (quo > sig_pack_pkg::C8_VMAX)
            ? sig_pack_pkg::C8_VMAX : quo;
          sig_pack_pkg::ST_SPECIAL: enc = (sc < sig_pack_pkg::C8_SPEC_LIM)
            ? sc + sig_pack_pkg::C8_SPEC_ADD : sig_pack_pkg::C8_SPEC_SAT;
          sig_pack_pkg::ST_ERROR: enc = sig_pack_pkg::C8_ERR;
          sig_pack_pkg::ST_NA: enc = sig_pack_pkg::C8_NA;
        endcase
      sig_pack_pkg::SIG_BYTE2:
        unique case (s_sig.state)
          sig_pack_pkg::ST_VALID: enc = (quo > sig_pack_pkg::C16_VMAX)
            ? sig_pack_pkg::C16_VMAX : quo;
          sig_pack_pkg::ST_SPECIAL: enc = (sc < sig_pack_pkg::C16_SPEC_LIM)
            ? sc + sig_pack_pkg::C16_SPEC_ADD : sig_pack_pkg::C16_SPEC_SAT;
          sig_pack_pkg::ST_ERROR: enc = (sc < sig_pack_pkg::C16_ERR_LIM)
            ? sc + sig_pack_pkg::C16_ERR_ADD : sig_pack_pkg::C16_ERR_SAT;
          sig_pack_pkg::ST_NA: enc = sig_pack_pkg::C16_NA;
        endcase
      sig_pack_pkg::SIG_BYTE4:
        unique case (s_sig.state)
          sig_pack_pkg::ST_VALID: enc = (quo > sig_pack_pkg::C32_VMAX)
            ? sig_pack_pkg::C32_VMAX : quo;
          sig_pack_pkg::ST_SPECIAL: enc = (sc < sig_pack_pkg::C32_SPEC_LIM)
            ? sc + sig_pack_pkg::C32_SPEC_ADD : sig_pack_pkg::C32_SPEC_SAT;
          sig_pack_pkg::ST_ERROR: enc = (sc < sig_pack_pkg::C32_ERR_LIM)
            ? sc + sig_pack_pkg::C32_ERR_ADD : sig_pack_pkg::C32_ERR_SAT;
          sig_pack_pkg::ST_NA: enc = sig_pack_pkg::C32_NA;
        endcase
      default: enc = 32'h0000_0000;
    endcase
  end

  // Field placement; bytes past byte 8 and bits past the byte edge are dropped.
  logic [63:0] fmask;
  logic [63:0] fdata;
  logic [7:0] dmask;
  always_comb
  begin
    dmask = 8'h00;
    unique case (s_type)
      sig_pack_pkg::SIG_BIT1: dmask = 8'h01 << s_bit;
      sig_pack_pkg::SIG_BIT2: dmask = 8'h03 << s_bit;
      sig_pack_pkg::SIG_BIT4: dmask = 8'h0F << s_bit;
      default: dmask = 8'h00;
    endcase
    // Continuous low byte at the chosen byte.
    if (s_cont)
    begin
      fmask = (s_type == sig_pack_pkg::SIG_BYTE1) ? 64'h0000_0000_0000_00FF
        : (s_type == sig_pack_pkg::SIG_BYTE2) ? 64'h0000_0000_0000_FFFF
        : 64'h0000_0000_FFFF_FFFF;
      fmask = fmask << {s_byte, 3'b000};
      fdata = {32'h0000_0000, enc} << {s_byte, 3'b000};
    end
    else
    begin
      // Discrete low bit at the chosen bit of the byte.
      fmask = {56'h0, dmask} << {s_byte, 3'b000};
      fdata = {56'h0, 8'(enc[7:0] << s_bit)} << {s_byte, 3'b000};
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      payload <= sig_pack_pkg::RST_PAYLOAD;
    end
    else if (pstate == sig_pack_pkg::PK_WRITE && s_live)
    begin
      payload <= (payload & ~fmask) | (fdata & fmask);
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      payload_out <= sig_pack_pkg::RST_PAYLOAD;
      payload_valid_out <= 1'b0;
      done_flag <= 1'b0;
    end
    else
    begin
      payload_valid_out <= (pstate == sig_pack_pkg::PK_DONE);
      if (pstate == sig_pack_pkg::PK_DONE)
      begin
        payload_out <= payload;
        done_flag <= 1'b1;
      end
      else if (pstate == sig_pack_pkg::PK_LOAD)
      begin
        done_flag <= 1'b0;
      end
    end
  end

  assign busy_out = (pstate != sig_pack_pkg::PK_IDLE);

  a_dead_slot_keep: assert property (@(posedge mclk_in) disable iff (rst_in)
    (pstate == sig_pack_pkg::PK_WRITE && !s_live) |=> $stable(payload))
    else $error("Dead slot changed the payload.");

  a_valid_clamp: assert property (@(posedge mclk_in) disable iff (rst_in)
    (pstate == sig_pack_pkg::PK_WRITE && s_type == sig_pack_pkg::SIG_BYTE2
      && s_sig.state == sig_pack_pkg::ST_VALID) |-> enc <= sig_pack_pkg::C16_VMAX)
    else $error("Valid two-byte code out of range.");

  a_one_bit_nonvalid: assert property (@(posedge mclk_in) disable iff (rst_in)
    (s_type == sig_pack_pkg::SIG_BIT1 && s_sig.state != sig_pack_pkg::ST_VALID) |-> enc == 1)
    else $error("One-bit non-valid code is not one.");

  a_two_bit_err: assert property (@(posedge mclk_in) disable iff (rst_in)
    (s_type == sig_pack_pkg::SIG_BIT2 && s_sig.state == sig_pack_pkg::ST_ERROR) |-> enc == 2)
    else $error("Two-bit error code is not two.");

  a_nibble_special: assert property (@(posedge mclk_in) disable iff (rst_in)
    (s_type == sig_pack_pkg::SIG_BIT4 && s_sig.state == sig_pack_pkg::ST_SPECIAL
      && s_sig.logical_state_code >= 12) |-> enc == 13)
    else $error("Four-bit special code does not saturate at 13.");

  a_byte_na: assert property (@(posedge mclk_in) disable iff (rst_in)
    (s_type == sig_pack_pkg::SIG_BYTE1 && s_sig.state == sig_pack_pkg::ST_NA) |-> enc == 255)
    else $error("One-byte not-available code is not 255.");

  a_div_length: assert property (@(posedge mclk_in) disable iff (rst_in)
    (pstate == sig_pack_pkg::PK_LOAD ##1 pstate == sig_pack_pkg::PK_DIV)
      |-> ##31 pstate == sig_pack_pkg::PK_DIV ##1 pstate == sig_pack_pkg::PK_WRITE)
    else $error("Division did not take thirty-two steps.");

  a_frame_done: assert property (@(posedge mclk_in) disable iff (rst_in)
    $rose(busy_out) |-> ##[2:180] payload_valid_out)
    else $error("Payload not delivered in time.");

endmodule : sig_packer

// *** bench/payload_sink.sv ***
// Receiving node model: latches each packed payload that the packer announces.
module payload_sink (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Payload from the packer
  input wire logic [63:0] payload_in,
  input wire logic valid_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] frame;
  int frames;
  // A receiver only trusts the payload in the cycle that it is announced.
  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      frame <= 64'h0;
      frames <= 0;
    end
    else if (valid_in)
    begin
      frame <= payload_in;
      frames <= frames + 1;
    end
  end
endmodule : payload_sink

// *** bench/tb.sv ***
// Self-checking bench of the output signal packer.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [3:0] cfg;
    logic [1:0] st;
    logic [31:0] code;
    logic [16:0] val;
    logic [31:0] exp;
  } row_t;
  logic mclk_in = 0, rst_in = 1, psel = 0, penable = 0, pwrite = 0, trig = 0, err;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic pready, pslverr, pvalid, busy;
  logic [63:0] payload;
  sig_pack_pkg::logical_sig_t [15:0] src = '0;
  int n_mismatch = 0, check_count = 0;
  row_t rows[27] = '{
    '{4'h1, 2'h0, 32'h0, 17'h0_7FFF, 32'h0}, '{4'h1, 2'h0, 32'h0, 17'h0_8000, 32'h1},
    '{4'h9, 2'h0, 32'h0, 17'h0_9000, 32'h0}, '{4'h1, 2'h2, 32'h5, 17'h0, 32'h1},
    '{4'h2, 2'h2, 32'h0, 17'h0, 32'h2}, '{4'h2, 2'h1, 32'h0, 17'h0, 32'h3},
    '{4'h2, 2'h3, 32'h0, 17'h0, 32'h3}, '{4'h3, 2'h1, 32'hB, 17'h0, 32'hD},
    '{4'h3, 2'h1, 32'hC, 17'h0, 32'hD}, '{4'h3, 2'h2, 32'h0, 17'h0, 32'hE},
    '{4'h3, 2'h3, 32'h0, 17'h0, 32'hF}, '{4'h4, 2'h0, 32'h0, 17'h0_8000, 32'hFA},
    '{4'h4, 2'h1, 32'h2, 17'h0, 32'hFD}, '{4'h4, 2'h1, 32'h3, 17'h0, 32'hFD},
    '{4'h4, 2'h2, 32'h0, 17'h0, 32'hFE}, '{4'h4, 2'h3, 32'h0, 17'h0, 32'hFF},
    '{4'h5, 2'h0, 32'h0, 17'h0_8000, 32'h1F4}, '{4'h5, 2'h3, 32'h0, 17'h0, 32'hFFFF},
    '{4'h5, 2'h1, 32'h2FF, 17'h0, 32'hFDFF}, '{4'h5, 2'h1, 32'h300, 17'h0, 32'hFDFF},
    '{4'h5, 2'h2, 32'hFF, 17'h0, 32'hFEFF}, '{4'h5, 2'h2, 32'h100, 17'h0, 32'hFEFF},
    '{4'h6, 2'h0, 32'h0, 17'h1_0000, 32'h3E8}, '{4'h6, 2'h1, 32'h0, 17'h0, 32'hFB00_0000},
    '{4'h6, 2'h1, 32'h0300_0000, 17'h0, 32'hFDFF_FFFF},
    '{4'h6, 2'h2, 32'h00FF_FFFF, 17'h0, 32'hFEFF_FFFF},
    '{4'h6, 2'h3, 32'h0, 17'h0, 32'hFFFF_FFFF}};

  initial
  begin
    forever #20 mclk_in = ~mclk_in;
  end

  sig_packer sig_packer_i (.mclk_in(mclk_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .sources_in(src),
    .trigger_in(trig), .payload_out(payload), .payload_valid_out(pvalid), .busy_out(busy));
  payload_sink payload_sink_i (.mclk_in(mclk_in), .rst_in(rst_in), .payload_in(payload),
    .valid_in(pvalid));

  task automatic close_out;
    if (n_mismatch == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Read data is loaded in the setup cycle, so it stands at the completing edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk_in);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      n_mismatch++;
      $display("wrong value at %0t: bus timeout", $time);
      close_out();
    end
  endtask : apb

  task automatic pack(input logic by_reg);
    int n, f0;
    f0 = payload_sink_i.frames;
    n = 0;
    if (by_reg)
      apb(1'b1, sig_pack_pkg::ADDR_CTRL, 32'h1);
    else
    begin
      @(posedge mclk_in);
      trig <= 1'b1;
      @(posedge mclk_in);
      trig <= 1'b0;
    end
    while (payload_sink_i.frames == f0 && n < 400)
    begin
      @(posedge mclk_in);
      #1 n++;
    end
    if (n >= 400)
    begin
      n_mismatch++;
      $display("wrong value at %0t: no payload", $time);
      close_out();
    end
  endtask : pack

  function automatic logic [31:0] mask(input logic [2:0] t);
    case (t)
      3'h1: return 32'h1;
      3'h2: return 32'h3;
      3'h3: return 32'hF;
      3'h4: return 32'hFF;
      3'h5: return 32'hFFFF;
      default: return 32'hFFFF_FFFF;
    endcase
  endfunction : mask

  initial
  begin
    repeat (4) @(posedge mclk_in);
    rst_in <= 1'b0;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, sig_pack_pkg::RST_CFG);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, sig_pack_pkg::RST_RES);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, sig_pack_pkg::RST_OFFSET);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, sig_pack_pkg::RST_MAX);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, sig_pack_pkg::RST_MIN);
    apb(1'b0, 8'hB0, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    apb(1'b1, 8'h0C, 32'h3E8);
    foreach (rows[i])
    begin
      apb(1'b1, 8'h00, 32'h0001_0110 | 32'(rows[i].cfg));
      src[0] <= '{rows[i].val, sig_pack_pkg::sig_state_t'(rows[i].st), rows[i].code};
      pack(1'b0);
      chk(payload_sink_i.frame[31:0] & mask(rows[i].cfg[2:0]), rows[i].exp);
    end
    apb(1'b1, 8'h08, 32'h64);
    apb(1'b1, 8'h00, 32'h0001_0115);
    src[0] <= '{17'h0_8000, sig_pack_pkg::ST_VALID, 32'h0};
    pack(1'b0);
    chk(payload_sink_i.frame[15:0], 16'h190);
    apb(1'b1, 8'h00, 32'h0001_0110);
    pack(1'b0);
    chk(payload_sink_i.frame[15:0], 16'h190);
    apb(1'b1, 8'h00, 32'h0000_0115);
    src[0] <= '{17'h0, sig_pack_pkg::ST_NA, 32'h0};
    pack(1'b0);
    chk(payload_sink_i.frame[15:0], 16'h190);
    apb(1'b1, 8'h20, 32'h0002_0532);
    apb(1'b1, 8'h40, 32'h0002_0175);
    src[1] <= '{17'h0, sig_pack_pkg::ST_ERROR, 32'h0};
    pack(1'b1);
    chk(payload_sink_i.frame[21:20], 2'h2);
    chk(payload_sink_i.frame[63:48], 16'hFE00);
    apb(1'b0, sig_pack_pkg::ADDR_STATUS, 32'h0);
    chk(rd, 32'h0000_0002);
    // A reset in the middle of a pass must stop it and clear the payload.
    @(posedge mclk_in);
    trig <= 1'b1;
    @(posedge mclk_in);
    trig <= 1'b0;
    repeat (3) @(posedge mclk_in);
    #1 chk(busy, 1'b1);
    @(posedge mclk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    #1 chk({busy, pvalid}, 2'b00);
    chk(payload, sig_pack_pkg::RST_PAYLOAD);
    apb(1'b0, 8'h20, 32'h0);
    chk(rd, sig_pack_pkg::RST_CFG);
    close_out();
  end
endmodule : tb
